//--- ocp_ctrl.sv
/*
 * Overcurrent protection control with AXI4-Lite registers.
 * Assumes ADC readings and PWM drives on the same clock; trip pins are
 * asynchronous. cycle_start pulses once per switching cycle.
 */
// Contract
// (RL1) Compare 8-bit limit against secondary reading
// (RL2) Flag when reading strictly exceeds limit
// (RL3) Software keeps limit at or below 0xfe
// (RL4) Debounce fast trip 0/40/80/120 ns
// (RL5) Fast trip blanks PWM rest of cycle
// (RL6) Balance enable modulates bridge B and D
// (RL7) Source select picks external flag pin
// (RL8) Constant current mode 10% below limit
// (RL9) Blanking ignores spike at measurement start
// (RL10) Timeout of 1/2/4/8 switching cycles
// (RL11) Recompare on each reading, flag sticky
`timescale 1ns/10ps
`default_nettype none
`include "ocp_cfg.svh"

module ocp_ctrl
    import ocp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write channels
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Current sense
    input wire ocp_reading_t secondary_current_sense,
    input wire logic primary_current_sense,
    input wire logic external_flag_input,
    input wire ocp_reading_t primary_sample,
    input wire logic primary_sample_bd,
    input wire logic measure_start,
    // PWM stage
    input wire logic cycle_start,
    input wire logic [3:0] pwm_in,
    output logic [3:0] pwm_out,
    output logic signed [7:0] balance_trim,
    output logic cc_active,
    // Interrupt
    output logic irq
);

    logic [7:0] limit_q; // Secondary overcurrent limit
    ocp_setting_t set_q; // Fast overcurrent setting
    ocp_status_t status_q; // Sticky events
    ocp_status_t mask_q; // Interrupt mask
    ocp_status_t event_d; // Events raised this cycle
    logic fast_trip; // Debounced fast trip level
    logic blank_q; // PWM blanked for rest of cycle
    logic [7:0] cc_level; // Constant current threshold
    logic cc_q; // Constant current region
    logic trip_seen_q; // Cycle had a fast trip
    logic [3:0] tmo_cnt_q; // Consecutive tripped cycles
    logic [3:0] tmo_need; // Cycles that make a timeout
    logic signed [9:0] bal_acc_q; // B minus D current integral
    logic skip_q; // Next primary sample is the spike
    logic [3:0] pwm_q; // Registered PWM drive
    logic signed [7:0] trim_q; // Registered balance trim
    logic bvalid_q; // Write response pending
    logic [1:0] bresp_q; // Write response code
    logic rvalid_q; // Read data pending
    logic [1:0] rresp_q; // Read response code
    logic [31:0] rdata_q; // Read data
    logic wr_go; // Write taken this cycle
    logic rd_go; // Read taken this cycle
    logic clr_wr; // Write-one-to-clear of status

    // Byte address to register index; low two bits are ignored
    function automatic logic [7:0] reg_idx(input logic [11:0] addr);
        reg_idx = addr[9:2];
    endfunction

    // Ninety percent of the limit, rounded down
    function automatic logic [7:0] ninety_pct(input logic [7:0] v);
        logic [11:0] prod;
        prod = 12'({4'h0, v} * 12'h009);
        ninety_pct = 8'(prod / 12'h00a);
    endfunction

    // Fast path: sync, source select and debounce
    ocp_fast_trip ocp_fast_trip_inst (
        .clk(clk),
        .nrst(nrst),
        .primary_current_sense(primary_current_sense),
        .external_flag_input(external_flag_input),
        .src_sel(set_q.src_sel),
        .debounce(set_q.debounce),
        .trip(fast_trip)
    );

    // AXI handshakes: address and data are taken together only
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign s_axi_arready = rd_go;
    assign clr_wr = wr_go && s_axi_wstrb[0] &&
        reg_idx(s_axi_awaddr) == `OCP_IDX_STATUS;

    // Software-written registers; only byte lane 0 holds data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            limit_q <= `OCP_RST_SEC_LIMIT;
            set_q <= `OCP_RST_FAST_SET;
            mask_q <= `OCP_RST_MASK;
        end else if (wr_go && s_axi_wstrb[0]) begin
            case (reg_idx(s_axi_awaddr))
                `OCP_IDX_SEC_LIMIT: limit_q <= s_axi_wdata[7:0];
                `OCP_IDX_FAST_SET: set_q <= s_axi_wdata[7:0];
                `OCP_IDX_MASK: mask_q <= s_axi_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `OCP_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            case (reg_idx(s_axi_awaddr))
                `OCP_IDX_SEC_LIMIT, `OCP_IDX_FAST_SET, `OCP_IDX_STATUS,
                `OCP_IDX_MASK, `OCP_IDX_STATE: bresp_q <= `OCP_RESP_OKAY;
                default: bresp_q <= `OCP_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read data path; reserved bits read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rresp_q <= `OCP_RESP_OKAY;
            rdata_q <= 32'h0;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= `OCP_RESP_OKAY;
            case (reg_idx(s_axi_araddr))
                `OCP_IDX_SEC_LIMIT: rdata_q <= {24'h0, limit_q};
                `OCP_IDX_FAST_SET: rdata_q <= {24'h0, set_q};
                `OCP_IDX_STATUS: rdata_q <= {28'h0, status_q};
                `OCP_IDX_MASK: rdata_q <= {28'h0, mask_q};
                `OCP_IDX_STATE: rdata_q <= {29'h0, blank_q, cc_q, fast_trip};
                default: begin
                    rdata_q <= 32'h0;
                    rresp_q <= `OCP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Constant current level tracks the limit; a limit of 0xff is
    // not allowed, so the strict compare below always can trip
    assign cc_level = ninety_pct(limit_q); // RL8 RL3

    // Constant current region, re-judged on every fresh reading
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cc_q <= 1'b0;
        end else if (!set_q.cc_en) begin
            cc_q <= 1'b0; // RL8
        end else if (secondary_current_sense.valid) begin
            cc_q <= secondary_current_sense.value > cc_level; // RL8
        end
    end
    assign cc_active = cc_q;

    // Events raised this cycle
    always_comb begin
        event_d = '0;
        event_d.sec_ocp = secondary_current_sense.valid &&
            (secondary_current_sense.value > limit_q); // RL1 RL2 RL11
        event_d.fast = fast_trip && !blank_q;
        event_d.timeout = cycle_start && trip_seen_q &&
            (tmo_cnt_q + 4'h1 >= tmo_need); // RL10
        event_d.cc = set_q.cc_en && secondary_current_sense.valid &&
            !cc_q && (secondary_current_sense.value > cc_level);
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= '0;
        end else if (clr_wr) begin
            status_q <= (status_q & ~s_axi_wdata[3:0]) | event_d; // RL11
        end else begin
            status_q <= status_q | event_d; // RL11
        end
    end

    assign irq = |(status_q & mask_q);

    // Blank PWM from a fast trip to the next cycle start; a trip that
    // lands on the cycle start blanks the new cycle too
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blank_q <= 1'b0;
        end else if (fast_trip) begin
            blank_q <= 1'b1; // RL5
        end else if (cycle_start) begin
            blank_q <= 1'b0;
        end
    end

    // Registered PWM drive, gated by blanking and the live trip
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwm_q <= 4'h0;
        end else if (fast_trip || blank_q) begin
            pwm_q <= 4'h0; // RL5
        end else begin
            pwm_q <= pwm_in;
        end
    end
    assign pwm_out = pwm_q;

    // Timeout: count switching cycles that saw a trip in a row
    assign tmo_need = 4'h1 << set_q.timeout; // RL10
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trip_seen_q <= 1'b0;
            tmo_cnt_q <= 4'h0;
        end else if (cycle_start) begin
            trip_seen_q <= fast_trip;
            if (!trip_seen_q || event_d.timeout) begin
                tmo_cnt_q <= 4'h0; // RL10
            end else begin
                tmo_cnt_q <= tmo_cnt_q + 4'h1;
            end
        end else if (fast_trip) begin
            trip_seen_q <= 1'b1;
        end
    end

    // Spike blanking: drop the first sample of each measurement
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            skip_q <= 1'b0;
        end else if (measure_start) begin
            skip_q <= set_q.blank; // RL9
        end else if (primary_sample.valid) begin
            skip_q <= 1'b0;
        end
    end

    // Integrate B-phase minus D-phase primary current, saturating;
    // the integral is held at zero while balance is off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bal_acc_q <= 10'sh0;
        end else if (!set_q.bal_en) begin
            bal_acc_q <= 10'sh0;
        end else if (primary_sample.valid && !skip_q) begin // RL9
            if (primary_sample_bd) begin
                bal_acc_q <= (bal_acc_q > 10'sh1ff - 10'sh0ff) ?
                    10'sh1ff : bal_acc_q + $signed({2'b00,
                    primary_sample.value}); // RL6
            end else begin
                bal_acc_q <= (bal_acc_q < -10'sh200 + 10'sh0ff) ?
                    -10'sh200 : bal_acc_q - $signed({2'b00,
                    primary_sample.value}); // RL6
            end
        end
    end

    // Trim: B gets minus trim and D plus trim in the PWM stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trim_q <= 8'sh0;
        end else begin
            trim_q <= set_q.bal_en ? bal_acc_q[9:2] : 8'sh0; // RL6
        end
    end
    assign balance_trim = trim_q;

    property p_sec_flag;
        @(posedge clk) disable iff (!nrst)
        (secondary_current_sense.valid &&
         secondary_current_sense.value > limit_q) |=> status_q.sec_ocp;
    endproperty
    a_sec_flag: assert property (p_sec_flag) // RL2
        else $error("Secondary overcurrent flag not set");

    property p_sec_quiet;
        @(posedge clk) disable iff (!nrst)
        (!status_q.sec_ocp && secondary_current_sense.valid &&
         secondary_current_sense.value <= limit_q && !clr_wr)
            |=> !status_q.sec_ocp;
    endproperty
    a_sec_quiet: assert property (p_sec_quiet) // RL1
        else $error("Secondary flag set at or below the limit");

    property p_sticky;
        @(posedge clk) disable iff (!nrst)
        (status_q.sec_ocp && !clr_wr) |=> status_q.sec_ocp;
    endproperty
    a_sticky: assert property (p_sticky) // RL11
        else $error("Secondary flag dropped without a clear");

    property p_blank;
        @(posedge clk) disable iff (!nrst)
        fast_trip |=> (pwm_out == 4'h0) && blank_q;
    endproperty
    a_blank: assert property (p_blank) // RL5
        else $error("PWM not blanked after fast trip");

    property p_blank_cycle;
        @(posedge clk) disable iff (!nrst)
        (blank_q && !cycle_start) |=> blank_q;
    endproperty
    a_blank_cycle: assert property (p_blank_cycle) // RL5
        else $error("Blanking ended inside the switching cycle");

    property p_cc;
        @(posedge clk) disable iff (!nrst)
        (set_q.cc_en && secondary_current_sense.valid &&
         secondary_current_sense.value > cc_level) |=> cc_active;
    endproperty
    a_cc: assert property (p_cc) // RL8
        else $error("Constant current mode not entered");

    property p_cc_off;
        @(posedge clk) disable iff (!nrst)
        !set_q.cc_en |=> !cc_active;
    endproperty
    a_cc_off: assert property (p_cc_off) // RL8
        else $error("Constant current active while disabled");

    property p_bal_off;
        @(posedge clk) disable iff (!nrst)
        !set_q.bal_en [*2] |-> balance_trim == 8'sh0;
    endproperty
    a_bal_off: assert property (p_bal_off) // RL6
        else $error("Balance trim nonzero while disabled");

    property p_skip;
        @(posedge clk) disable iff (!nrst)
        (skip_q && primary_sample.valid && set_q.bal_en)
            |=> $stable(bal_acc_q);
    endproperty
    a_skip: assert property (p_skip) // RL9
        else $error("Blanked spike sample was integrated");

    property p_tmo_one;
        @(posedge clk) disable iff (!nrst)
        (set_q.timeout == 2'b00 && cycle_start && trip_seen_q)
            |=> status_q.timeout;
    endproperty
    a_tmo_one: assert property (p_tmo_one) // RL10
        else $error("One-cycle fast trip timeout missed");

endmodule
`default_nettype wire

//--- ocp_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * overcurrent protection control block.
 * Assumes a 40 MHz system clock and an AXI4-Lite register port.
 */
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// Register indices; the byte address is four times the index
`define OCP_IDX_SEC_LIMIT 8'h26
`define OCP_IDX_FAST_SET 8'h27
`define OCP_IDX_STATUS 8'h2a
`define OCP_IDX_MASK 8'h2b
`define OCP_IDX_STATE 8'h2c

// Field positions of the fast overcurrent setting register
`define OCP_FLD_DEB_HI 7
`define OCP_FLD_DEB_LO 6
`define OCP_FLD_BAL_EN 5
`define OCP_FLD_SRC_SEL 4
`define OCP_FLD_CC_EN 3
`define OCP_FLD_BLANK 2
`define OCP_FLD_TMO_HI 1
`define OCP_FLD_TMO_LO 0

// Status and mask bit positions
`define OCP_ST_SEC_OCP 0
`define OCP_ST_FAST 1
`define OCP_ST_TIMEOUT 2
`define OCP_ST_CC 3

// Reset values
`define OCP_RST_SEC_LIMIT 8'hfe
`define OCP_RST_FAST_SET 8'h00
`define OCP_RST_MASK 4'h0

// Timing: clock period and debounce times in ns
`define OCP_CLK_PERIOD_NS 25
`define OCP_DEB1_NS 40
`define OCP_DEB2_NS 80
`define OCP_DEB3_NS 120
`define OCP_DEB1_CYC \
    ((`OCP_DEB1_NS + `OCP_CLK_PERIOD_NS - 1) / `OCP_CLK_PERIOD_NS)
`define OCP_DEB2_CYC \
    ((`OCP_DEB2_NS + `OCP_CLK_PERIOD_NS - 1) / `OCP_CLK_PERIOD_NS)
`define OCP_DEB3_CYC \
    ((`OCP_DEB3_NS + `OCP_CLK_PERIOD_NS - 1) / `OCP_CLK_PERIOD_NS)

// AXI responses
`define OCP_RESP_OKAY 2'b00
`define OCP_RESP_SLVERR 2'b10

`endif

//--- ocp_pkg.sv
/*
 * Types shared by the overcurrent protection control files.
 * Assumes ocp_cfg.svh for the numeric layout.
 */
package ocp_pkg;

    // Fields of the fast overcurrent setting register, bit 7 first
    typedef struct packed {
        logic [1:0] debounce;    // Fast trip debounce code
        logic bal_en;            // Volt-second balance enable
        logic src_sel;           // Fast trip taken from external flag
        logic cc_en;             // Constant current mode enable
        logic blank;             // Balance spike blanking
        logic [1:0] timeout;     // Fast trip timeout code
    } ocp_setting_t;

    // Sticky event bits, bit 3 first
    typedef struct packed {
        logic cc;                // Entered constant current region
        logic timeout;           // Fast trip persisted too many cycles
        logic fast;              // Debounced fast trip
        logic sec_ocp;           // Secondary accurate overcurrent
    } ocp_status_t;

    // Secondary or primary current reading with its strobe
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } ocp_reading_t;

endpackage

//--- ocp_fast_trip.sv
/*
 * Fast overcurrent trip: synchronises both trip pins, selects the source
 * and debounces it. Assumes pins are asynchronous comparator levels.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ocp_cfg.svh"

module ocp_fast_trip
    import ocp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pins
    input wire logic primary_current_sense,
    input wire logic external_flag_input,
    // Settings
    input wire logic src_sel,
    input wire logic [1:0] debounce,
    // Result
    output logic trip
);

    logic [1:0] meta_q;          // First synchroniser stage
    logic [1:0] sync_q;          // Second stage, safe to read
    logic above;                 // Selected source level
    logic [2:0] cnt_q;           // Cycles the source has been above
    logic [2:0] need;            // Cycles required by the debounce code

    // Debounce code to a cycle count, least times rounded up
    function automatic logic [2:0] deb_cycles(input logic [1:0] code);
        case (code)
            2'b01: deb_cycles = 3'(`OCP_DEB1_CYC);
            2'b10: deb_cycles = 3'(`OCP_DEB2_CYC);
            2'b11: deb_cycles = 3'(`OCP_DEB3_CYC);
            default: deb_cycles = 3'h0;
        endcase
    endfunction

    // Two-flop synchronisers for both pins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end else begin
            meta_q <= {external_flag_input, primary_current_sense};
            sync_q <= meta_q;
        end
    end

    assign above = src_sel ? sync_q[1] : sync_q[0]; // RL7
    assign need = deb_cycles(debounce);

    // Count consecutive cycles above; saturates so a long event holds
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 3'h0;
        end else if (!above) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign trip = above && (cnt_q >= need); // RL4

    property p_deb_hold;
        @(posedge clk) disable iff (!nrst)
        (trip && debounce == 2'b11) |->
            $past(above, 1) && $past(above, 5);
    endproperty
    a_deb_hold: assert property (p_deb_hold) // RL4
        else $error("Fast trip before 120 ns debounce");

    property p_src_ext;
        @(posedge clk) disable iff (!nrst)
        (src_sel && debounce == 2'b00 && sync_q[1]) |-> trip;
    endproperty
    a_src_ext: assert property (p_src_ext) // RL7
        else $error("External flag did not trip fast path");

endmodule
`default_nettype wire

//--- ocp_far.sv
/*
 * Far-side model: sense converter strobes and the raw PWM stage.
 * Assumes its tasks are started just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module ocp_far
    import ocp_pkg::*;
(
    // Clock
    input wire logic clk,
    // Converter side
    output ocp_reading_t sec_rd,
    output ocp_reading_t pri_rd,
    output logic pri_bd,
    output logic meas_start,
    // PWM stage
    output logic cyc_start,
    output logic [3:0] pwm_drv
);
    // Payload is scrambled while no strobe is up, so stale data never helps
    initial begin
        sec_rd = 9'h0a5;
        pri_rd = 9'h05a;
        pri_bd = 1'b0;
        meas_start = 1'b0;
        cyc_start = 1'b0;
        pwm_drv = 4'ha;
    end

    // One calibrated reading per strobe, then two quiet cycles
    task automatic rdg(input logic [7:0] v);
        sec_rd <= {1'b1, v};
        @(posedge clk);
        sec_rd <= {1'b0, ~v};
        repeat (2) @(posedge clk);
    endtask

    // B-phase primary sample, optionally after a measurement start
    task automatic smp(input logic [7:0] v, input logic first);
        meas_start <= first;
        @(posedge clk);
        meas_start <= 1'b0;
        pri_rd <= {1'b1, v};
        pri_bd <= 1'b1;
        @(posedge clk);
        pri_rd <= {1'b0, ~v};
        pri_bd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Marks the start of a new switching cycle
    task automatic cyc();
        cyc_start <= 1'b1;
        @(posedge clk);
        cyc_start <= 1'b0;
        @(posedge clk);
    endtask
endmodule

`default_nettype wire

//--- overcurrent_protection_control_tb.sv
/*
 * Self-checking bench for the overcurrent protection control block.
 * Assumes ocp_far for readings and PWM; registers over AXI4-Lite.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ocp_cfg.svh"

module overcurrent_protection_control_tb
    import ocp_pkg::*;
    ;
    localparam logic [1:0] OK = `OCP_RESP_OKAY;
    localparam logic [1:0] ER = `OCP_RESP_SLVERR;
    // Byte address is four times the register index
    localparam logic [11:0] A_LIM = {2'b00, `OCP_IDX_SEC_LIMIT, 2'b00};
    localparam logic [11:0] A_SET = {2'b00, `OCP_IDX_FAST_SET, 2'b00};
    localparam logic [11:0] A_STA = {2'b00, `OCP_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {2'b00, `OCP_IDX_MASK, 2'b00};
    localparam logic [11:0] A_BAD = 12'h0a0; // Unmapped word

    // Bus master state, all defined at time zero
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic pin_pri = 1'b0, pin_ext = 1'b0; // Trip pins
    logic awready, wready, bvalid, arready, rvalid, cc_active, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] pwm_in, pwm_out;
    logic signed [7:0] trim;
    ocp_reading_t sec_rd, pri_rd;
    logic pri_bd, meas_start, cyc_start;
    int err_count = 0;
    int n_compared = 0;
    int lat0, lat, c;

    // 40 MHz
    always #12.5 clk = ~clk;

    ocp_ctrl ocp_ctrl_inst (
        .clk(clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .secondary_current_sense(sec_rd), .primary_current_sense(pin_pri),
        .external_flag_input(pin_ext), .primary_sample(pri_rd),
        .primary_sample_bd(pri_bd), .measure_start(meas_start),
        .cycle_start(cyc_start), .pwm_in(pwm_in), .pwm_out(pwm_out),
        .balance_trim(trim), .cc_active(cc_active), .irq(irq)
    );

    ocp_far ocp_far_inst (
        .clk(clk), .sec_rd(sec_rd), .pri_rd(pri_rd), .pri_bd(pri_bd),
        .meas_start(meas_start), .cyc_start(cyc_start), .pwm_drv(pwm_in)
    );

    // Verdict and end of run
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Counts a comparison; a mismatch is reported at once
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // A wait that ran out counts and ends the run
    task automatic give_up(input string n);
        err_count++;
        $display("[ERR] %s expected answer seen timeout", n);
        complete_run();
    endtask

    // Write; each channel drops at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [1:0] er);
        int k;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        if (k == 40) give_up("write");
        chk("bresp", er, bresp);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    // Read and compare data and response
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
            input logic [1:0] er);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        if (k == 40) give_up("read");
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    // Edges until the PWM outputs go dark, bounded
    task automatic until_dark(output int n);
        for (n = 1; n < 30; n++) begin
            @(posedge clk);
            if (pwm_out === 4'h0) break;
        end
        if (n == 30) give_up("trip");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset contents and an unmapped place
        rd(A_LIM, 32'hfe, OK);
        rd(A_SET, 32'h0, OK);
        rd(A_BAD, 32'h0, ER);
        wr(A_BAD, 32'h5, ER);
        // Strict compare, sticky flag, mask and clear
        wr(A_MSK, 32'h1, OK);
        wr(A_LIM, 32'h80, OK);
        ocp_far_inst.rdg(8'h80);
        rd(A_STA, 32'h0, OK);
        ocp_far_inst.rdg(8'h81);
        ocp_far_inst.rdg(8'h10);
        rd(A_STA, 32'h1, OK);
        chk("irq", 1, irq);
        wr(A_MSK, 32'h0, OK);
        chk("irq", 0, irq);
        wr(A_STA, 32'h1, OK);
        rd(A_STA, 32'h0, OK);
        // Constant current starts above nine tenths of the limit
        wr(A_LIM, 32'd100, OK);
        wr(A_SET, 32'h8, OK);
        ocp_far_inst.rdg(8'((100 * 9) / 10 + 1));
        chk("cc", 1, cc_active);
        rd(A_STA, 32'h8, OK);
        ocp_far_inst.rdg(8'((100 * 9) / 10));
        chk("cc", 0, cc_active);
        // Each debounce code adds its time in whole cycles, rounded up
        for (c = 0; c < 4; c++) begin
            wr(A_SET, 32'(c) << 6, OK);
            wr(A_STA, 32'hf, OK);
            pin_pri <= 1'b1;
            until_dark(lat);
            if (c == 0) lat0 = lat;
            chk("debounce", (c * 40 + 24) / 25, lat - lat0);
            pin_pri <= 1'b0;
            repeat (8) @(posedge clk);
            chk("blank", 0, pwm_out);
            ocp_far_inst.cyc();
            repeat (2) @(posedge clk);
            chk("resume", pwm_in, pwm_out);
            rd(A_STA, 32'h6, OK);
        end
        // Two tripped cycles are needed for the second timeout code
        wr(A_SET, 32'h1, OK);
        wr(A_STA, 32'hf, OK);
        pin_pri <= 1'b1;
        until_dark(lat);
        ocp_far_inst.cyc();
        rd(A_STA, 32'h2, OK);
        ocp_far_inst.cyc();
        rd(A_STA, 32'h6, OK);
        pin_pri <= 1'b0;
        // External flag replaces the primary comparator
        wr(A_SET, 32'h10, OK);
        ocp_far_inst.cyc();
        wr(A_STA, 32'hf, OK);
        pin_pri <= 1'b1;
        repeat (10) @(posedge clk);
        chk("pri ignored", pwm_in, pwm_out);
        pin_pri <= 1'b0;
        pin_ext <= 1'b1;
        until_dark(lat);
        rd(A_STA, 32'h2, OK);
        pin_ext <= 1'b0;
        // Balance trim: blanked first sample, then a counted one
        wr(A_SET, 32'h24, OK);
        ocp_far_inst.smp(8'h40, 1'b1);
        chk("trim", 0, trim);
        ocp_far_inst.smp(8'h40, 1'b0);
        chk("trim", 8'h40 >> 2, trim);
        wr(A_SET, 32'h0, OK);
        chk("trim off", 0, trim);
        complete_run();
    end
endmodule

`default_nettype wire
